/* logic/ttx_pkg.sv */
package ttx_pkg;

   // ------------------------------------------------------------
   // Clock and rate figures
   // ------------------------------------------------------------
   localparam int CLK_NS         = 50;
   localparam int CLK_HBPS       = 1000000000 / CLK_NS / 100;
   localparam int RATE_625_HBPS  = 69375;
   localparam int RATE_525_HBPS  = 57272;
   localparam int T_INS_625_NS   = 9780;
   localparam int T_INS_525_NS   = 10500;
   localparam int INS_625_CYC    = (T_INS_625_NS + CLK_NS - 1) / CLK_NS;
   localparam int INS_525_CYC    = (T_INS_525_NS + CLK_NS - 1) / CLK_NS;
   localparam int BITS_625       = 360;
   localparam int BITS_WST       = 296;
   localparam int BITS_NABTS     = 288;

   // ------------------------------------------------------------
   // Register indices; byte address is four times the index
   // ------------------------------------------------------------
   localparam logic [7:0] IX_STATUS = 8'h60;
   localparam logic [7:0] IX_MODE   = 8'h6B;
   localparam logic [7:0] IX_CTRL   = 8'h6F;
   localparam logic [7:0] IX_HSTART = 8'h73;
   localparam logic [7:0] IX_DELAY  = 8'h74;
   localparam logic [7:0] IX_OVS    = 8'h76;
   localparam logic [7:0] IX_OVE    = 8'h77;
   localparam logic [7:0] IX_EVS    = 8'h78;
   localparam logic [7:0] IX_EVE    = 8'h79;
   localparam logic [7:0] IX_MSB    = 8'h7C;

   // ------------------------------------------------------------
   // Field positions and values after reset
   // ------------------------------------------------------------
   localparam int         EN_BIT     = 5;
   localparam int         UNDER_BIT  = 2;
   localparam int         OVS8_BIT   = 0;
   localparam int         EVS8_BIT   = 1;
   localparam int         OVE8_BIT   = 2;
   localparam int         EVE8_BIT   = 3;
   localparam logic [7:0] RST_HSTART = 8'h00;
   localparam logic [3:0] RST_DELAY  = 4'h0;
   localparam logic [8:0] RST_LINE   = 9'h000;

   // ------------------------------------------------------------
   // Buffer shape
   // ------------------------------------------------------------
   localparam int BUF_DEPTH = 2;
   localparam int BUF_WIDTH = 1;
   localparam int BUF_AW    = 1;

   typedef enum logic [1:0] {
      STD_625,
      STD_WST,
      STD_NABTS
   } ttx_std_t;

   function automatic logic [8:0] win_bits(input ttx_std_t s);
      case (s)
         STD_625: win_bits = 9'(BITS_625);
         STD_WST: win_bits = 9'(BITS_WST);
         default: win_bits = 9'(BITS_NABTS);
      endcase
   endfunction

   function automatic logic [18:0] bit_rate(input ttx_std_t s);
      bit_rate = (s == STD_625) ? 19'(RATE_625_HBPS) : 19'(RATE_525_HBPS);
   endfunction

   function automatic logic [10:0] ins_start(input ttx_std_t s);
      ins_start = (s == STD_625) ? 11'(INS_625_CYC) : 11'(INS_525_CYC);
   endfunction

endpackage

/* logic/bit_stream_if.sv */
`timescale 1ns/1ps
interface bit_stream_if;
   logic                          valid;
   logic                          ready;
   logic [ttx_pkg::BUF_WIDTH-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* logic/ttx_pair_buffer.sv */
`timescale 1ns/1ps
module ttx_pair_buffer import ttx_pkg::*; (
   // Clock and reset
   input wire logic    core_clk,
   input wire logic    reset,
   // Streams
   bit_stream_if.snk   fill,
   bit_stream_if.src   drain
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [BUF_DEPTH-1:0][BUF_WIDTH-1:0] mem;
      logic [BUF_AW-1:0]                   wp;
      logic [BUF_AW-1:0]                   rp;
      logic [BUF_AW:0]                     cnt;
   } buf_state_t;

   buf_state_t s_r;
   buf_state_t s_nxt;
   logic       push;
   logic       pop;

   function automatic logic [BUF_AW-1:0] wrap(input logic [BUF_AW-1:0] p);
      wrap = (p == BUF_AW'(BUF_DEPTH - 1)) ? '0 : BUF_AW'(p + 1'b1);
   endfunction

   assign fill.ready  = (s_r.cnt != (BUF_AW + 1)'(BUF_DEPTH));
   assign drain.valid = (s_r.cnt != '0);
   assign drain.data  = s_r.mem[s_r.rp];
   assign push        = fill.valid && fill.ready;
   assign pop         = drain.valid && drain.ready;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wp] = fill.data;
         s_nxt.wp          = wrap(s_r.wp);
      end
      if (pop) begin
         s_nxt.rp = wrap(s_r.rp);
      end
      case ({push, pop})
         2'b10:   s_nxt.cnt = s_r.cnt + 1'b1;
         2'b01:   s_nxt.cnt = s_r.cnt - 1'b1;
         default: s_nxt.cnt = s_r.cnt;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule // ttx_pair_buffer

/* logic/ttx_insert.sv */
// Notes on behaviour
// [R1] Insertion starts 9.78us or 10.5us after sync.
// [R2] Source gives one bit per request pulse.
// [R3] Sampling point delayed by programmed request delay.
// [R4] Requests begin at programmed horizontal start.
// [R5] 625-line window: 360 bits at 6.9375 Mbit/s.
// [R6] World standard window: 296 bits, 5.7272 Mbit/s.
// [R7] NABTS window: 288 bits, 5.7272 Mbit/s.
// [R8] Enable bit low keeps window closed.
// [R9] Insert only inside odd/even field line ranges.
// [R10] Host configures shared pins before use.
// [R11] Request delay is low nibble at index 74h.
// [R12] Request output idle outside window and lines.
`timescale 1ns/1ps
module ttx_insert import ttx_pkg::*; (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Avalon-MM slave
   input  wire logic [9:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output wire logic [31:0] readdata,
   output wire logic        waitrequest,
   // Video timing
   input  wire logic        line_start,
   input  wire logic        field_start,
   input  wire logic        odd_field,
   // Teletext source
   input  wire logic        teletext_serial_in,
   output wire logic        bit_request_out,
   // Insertion into the video path
   output wire logic        insert_active,
   output wire logic        insert_bit
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic        en;
      ttx_std_t    std;
      logic [7:0]  hstart;
      logic [3:0]  delay;
      logic [8:0]  ovs;
      logic [8:0]  ove;
      logic [8:0]  evs;
      logic [8:0]  eve;
      logic        busy;
      logic [7:0]  rdata;
      logic [10:0] hcnt;
      logic [8:0]  line;
      logic        line_ok;
      logic [18:0] req_acc;
      logic [18:0] ins_acc;
      logic        req_on;
      logic        req_pend;
      logic        req_out;
      logic [8:0]  req_n;
      logic [15:0] hist;
      logic [4:0]  inflight;
      logic        ins_on;
      logic [8:0]  ins_n;
      logic        ins_bit;
      logic        underrun;
   } state_t;

   localparam state_t RST_STATE = '{
      busy:    1'b1,
      std:     STD_625,
      hstart:  RST_HSTART,
      delay:   RST_DELAY,
      ovs:     RST_LINE,
      ove:     RST_LINE,
      evs:     RST_LINE,
      eve:     RST_LINE,
      default: '0
   };

   state_t      s_r;
   state_t      s_nxt;
   logic [7:0]  index;
   logic        go;
   logic [18:0] req_sum;
   logic [18:0] ins_sum;
   logic        req_tick;
   logic        ins_tick;
   logic        pend_now;
   logic        issue;
   logic        capture;
   logic        pop;
   logic        drain;
   logic [8:0]  bits;
   logic [8:0]  next_line;

   bit_stream_if fill_if ();
   bit_stream_if drain_if ();

   ttx_pair_buffer ttx_pair_buffer_i (
      .core_clk (core_clk),
      .reset    (reset),
      .fill     (fill_if),
      .drain    (drain_if)
   );

   function automatic logic in_range(input logic [8:0] l,
                                     input logic [8:0] lo,
                                     input logic [8:0] hi);
      in_range = (l >= lo) && (l <= hi);
   endfunction

   function automatic logic [18:0] acc_step(input logic [18:0] sum);
      acc_step = (sum >= 19'(CLK_HBPS)) ? 19'(sum - 19'(CLK_HBPS)) : sum;
   endfunction

   // ------------------------------------------------------------
   // Combinational terms
   // ------------------------------------------------------------
   assign index     = address[9:2];
   assign bits      = win_bits(s_r.std);                 // [R5] [R6] [R7]
   assign go        = s_r.en && s_r.line_ok;             // [R8] [R9]
   assign req_sum   = s_r.req_acc + bit_rate(s_r.std);   // [R5] [R6] [R7]
   assign ins_sum   = s_r.ins_acc + bit_rate(s_r.std);
   assign req_tick  = s_r.req_on && (req_sum >= 19'(CLK_HBPS));
   assign ins_tick  = s_r.ins_on && (ins_sum >= 19'(CLK_HBPS));
   assign pend_now  = s_r.req_pend || req_tick;
   // Only one bit may be in flight, so the buffer can never overflow.
   assign issue     = s_r.req_on && pend_now && fill_if.ready
                      && (s_r.inflight == '0) && !line_start; // [R12]
   assign capture   = s_r.hist[s_r.delay];               // [R3] [R2]
   assign pop       = ins_tick;
   // Leftover bits from an earlier line are discarded before requesting.
   assign drain     = !s_r.req_on && !s_r.ins_on && (s_r.req_n == '0)
                      && (s_r.inflight == '0);
   assign next_line = field_start ? 9'h001 : 9'(s_r.line + 1'b1);

   assign fill_if.valid  = capture;
   assign fill_if.data   = teletext_serial_in;
   assign drain_if.ready = pop || drain;

   assign readdata        = {24'h000000, s_r.rdata};
   assign waitrequest     = s_r.busy;
   assign bit_request_out = s_r.req_out;
   assign insert_active   = s_r.ins_on;
   assign insert_bit      = s_r.ins_bit;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;

      // ------------------------------------------------------------
      // Bus slave: one wait cycle, then the access completes.
      // ------------------------------------------------------------
      if (s_r.busy) begin
         if (read || write) begin
            s_nxt.busy = 1'b0;
            case (index)
               IX_STATUS: s_nxt.rdata = {5'h00, s_r.underrun,
                                         s_r.ins_on, s_r.req_on};
               IX_MODE:   s_nxt.rdata = {6'h00, s_r.std};
               IX_CTRL:   s_nxt.rdata = 8'(s_r.en) << EN_BIT;
               IX_HSTART: s_nxt.rdata = s_r.hstart;
               IX_DELAY:  s_nxt.rdata = {4'h0, s_r.delay};  // [R11]
               IX_OVS:    s_nxt.rdata = s_r.ovs[7:0];
               IX_OVE:    s_nxt.rdata = s_r.ove[7:0];
               IX_EVS:    s_nxt.rdata = s_r.evs[7:0];
               IX_EVE:    s_nxt.rdata = s_r.eve[7:0];
               IX_MSB:    s_nxt.rdata = {4'h0, s_r.eve[8], s_r.ove[8],
                                         s_r.evs[8], s_r.ovs[8]};
               default:   s_nxt.rdata = 8'h00;
            endcase
         end
      end else begin
         s_nxt.busy = 1'b1;
         if (write && byteenable[0]) begin
            case (index)
               IX_STATUS: begin
                  if (writedata[UNDER_BIT]) begin
                     s_nxt.underrun = 1'b0;
                  end
               end
               IX_MODE: begin
                  s_nxt.std = (writedata[1:0] == 2'h3) ? STD_NABTS
                              : ttx_std_t'(writedata[1:0]);
               end
               IX_CTRL:   s_nxt.en = writedata[EN_BIT];
               IX_HSTART: s_nxt.hstart = writedata[7:0];    // [R4]
               IX_DELAY:  s_nxt.delay = writedata[3:0];     // [R11]
               IX_OVS:    s_nxt.ovs[7:0] = writedata[7:0];  // [R9]
               IX_OVE:    s_nxt.ove[7:0] = writedata[7:0];
               IX_EVS:    s_nxt.evs[7:0] = writedata[7:0];
               IX_EVE:    s_nxt.eve[7:0] = writedata[7:0];
               IX_MSB: begin
                  s_nxt.ovs[8] = writedata[OVS8_BIT];
                  s_nxt.evs[8] = writedata[EVS8_BIT];
                  s_nxt.ove[8] = writedata[OVE8_BIT];
                  s_nxt.eve[8] = writedata[EVE8_BIT];
               end
               default: begin
               end
            endcase
         end
      end

      // ------------------------------------------------------------
      // Line and field position.
      // ------------------------------------------------------------
      if (line_start) begin
         s_nxt.hcnt     = '0;
         s_nxt.line     = next_line;
         s_nxt.line_ok  = odd_field                      // [R9]
                          ? in_range(next_line, s_r.ovs, s_r.ove)
                          : in_range(next_line, s_r.evs, s_r.eve);
         s_nxt.req_on   = 1'b0;
         s_nxt.req_pend = 1'b0;
         s_nxt.req_n    = '0;
         s_nxt.ins_on   = 1'b0;
      end else begin
         if (s_r.hcnt != '1) begin
            s_nxt.hcnt = s_r.hcnt + 1'b1;
         end

         // ------------------------------------------------------------
         // Request phase.
         // ------------------------------------------------------------
         if (go && !s_r.req_on && (s_r.req_n == '0)
             && (s_r.hcnt == {3'h0, s_r.hstart})) begin     // [R4]
            s_nxt.req_on   = 1'b1;
            s_nxt.req_acc  = '0;
            // The first bit is asked for at once, so the start point
            // does not drift with the bit rate of the standard.
            s_nxt.req_pend = 1'b1;                      // [R4]
         end
         if (s_r.req_on) begin
            s_nxt.req_acc  = acc_step(req_sum);
            s_nxt.req_pend = pend_now && !issue;
         end
         if (issue) begin
            s_nxt.req_n = s_r.req_n + 1'b1;
            if (9'(s_r.req_n + 1'b1) == bits) begin        // [R12]
               s_nxt.req_on   = 1'b0;
               s_nxt.req_pend = 1'b0;
            end
         end

         // ------------------------------------------------------------
         // Insertion phase, fixed distance from sync.
         // ------------------------------------------------------------
         if (go && !s_r.ins_on && (s_r.ins_n == '0)
             && (s_r.hcnt == ins_start(s_r.std))) begin     // [R1]
            s_nxt.ins_on  = 1'b1;
            s_nxt.ins_acc = '0;
         end
         if (s_r.ins_on) begin
            s_nxt.ins_acc = acc_step(ins_sum);
         end
         if (pop) begin
            s_nxt.ins_bit = drain_if.valid ? drain_if.data[0] : 1'b0;
            s_nxt.ins_n   = s_r.ins_n + 1'b1;
            if (9'(s_r.ins_n + 1'b1) == bits) begin        // [R5]
               s_nxt.ins_on = 1'b0;
            end
         end
      end

      if (line_start || !s_r.ins_on) begin
         s_nxt.ins_n = (line_start) ? '0 : s_nxt.ins_n;
      end

      // Clearing the enable shuts both phases at once.
      if (!s_r.en) begin
         s_nxt.req_on   = 1'b0;                          // [R8]
         s_nxt.req_pend = 1'b0;
         s_nxt.ins_on   = 1'b0;
      end

      // ------------------------------------------------------------
      // Request pulse is one cycle wide per bit.
      // ------------------------------------------------------------
      s_nxt.req_out  = issue;                            // [R2] [R12]
      s_nxt.hist     = {s_r.hist[14:0], s_r.req_out};    // [R3]
      // One bit in flight caps the rate at one per delay plus three.
      s_nxt.inflight = 5'(s_r.inflight + {4'h0, issue}
                          - {4'h0, capture});

      // ------------------------------------------------------------
      // An underrun set in the same cycle as a clear is kept.
      // ------------------------------------------------------------
      if (pop && !drain_if.valid) begin
         s_nxt.underrun = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_r <= RST_STATE;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule // ttx_insert

/* verif/ttx_insert_monitor.sv */
`timescale 1ns/1ps
module ttx_insert_monitor import ttx_pkg::*; (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        reset,
   // Register bus
   input wire logic [9:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // Video and source side
   input wire logic        line_start,
   input wire logic        bit_request_out,
   input wire logic        insert_active
);
   // Requests seen in the current line, cleared at each line start.
   logic [9:0] req_cnt_r;

   always_ff @(posedge core_clk) begin
      if (reset || line_start) req_cnt_r <= 10'h000;
      else if (bit_request_out) req_cnt_r <= req_cnt_r + 10'h001;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   AST_REQ_PULSE: assert property (
      $rose(bit_request_out) |=> !bit_request_out [*2])
      else $error("request pulse too long or gap too short");
   AST_REQ_MAX: assert property (req_cnt_r <= 10'h168)
      else $error("more requests than window bits");
   AST_REQ_LATE: assert property (
      line_start |=> !bit_request_out)
      else $error("request before horizontal start");
   AST_INS_LATE: assert property (
      line_start |=> !insert_active [*8])
      else $error("insertion opened too early");
   AST_WAIT_ONE: assert property (
      !waitrequest |=> waitrequest)
      else $error("waitrequest low longer than one cycle");
   AST_WAIT_CAUSE: assert property (
      $fell(waitrequest) |-> $past(read || write))
      else $error("bus answer without request");
   AST_WAIT_IDLE: assert property (
      (waitrequest && !read && !write) |=> waitrequest)
      else $error("bus answer while idle");
   AST_DELAY_NIB: assert property (
      (!waitrequest && read && address[9:2] == IX_DELAY)
      |-> readdata[31:4] == 28'h0)
      else $error("delay register has bits above low nibble");
endmodule // ttx_insert_monitor

bind ttx_insert ttx_insert_monitor ttx_insert_monitor_i (
   .core_clk(core_clk), .reset(reset), .address(address), .read(read),
   .write(write), .readdata(readdata), .waitrequest(waitrequest),
   .line_start(line_start), .bit_request_out(bit_request_out),
   .insert_active(insert_active));

/* verif/ttx_source_model.sv */
`timescale 1ns/1ps
module ttx_source_model (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset,
   // Request and data pair
   input  wire logic       bit_request_out,
   input  wire logic [3:0] request_data_delay,
   output logic            teletext_serial_in
);
   logic [15:0] hist_r;
   logic        next_r;
   wire  [15:0] seen = {hist_r[14:0], bit_request_out};

   // Data are valid for one cycle only; otherwise the line toggles, so a
   // sample taken at the wrong delay reads garbage, not a stale bit.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         hist_r             <= 16'h0000;
         next_r             <= 1'h1;
         teletext_serial_in <= 1'h0;
      end else begin
         hist_r <= seen;
         if (seen[request_data_delay]) begin
            teletext_serial_in <= next_r;
            next_r             <= ~next_r;
         end else begin
            teletext_serial_in <= ~teletext_serial_in;
         end
      end
   end
endmodule // ttx_source_model

/* verif/test_teletext_insert_timing.sv */
`timescale 1ns/1ps
module test_teletext_insert_timing import ttx_pkg::*;;
   typedef struct {
      logic [7:0] mode;
      logic [7:0] hs;
      int         bits;
      int         rate;
      int         ins;
      bit         dat;
   } row_t;

   // The 625 row underruns by design, so only its timing and underrun flag are compared.
   row_t rows [4] = '{'{8'h00, 8'h10, 360, 69375, 196, 1'h0},
                      '{8'h01, 8'h10, 296, 57272, 210, 1'h1},
                      '{8'h02, 8'h30, 288, 57272, 210, 1'h1},
                      '{8'h03, 8'h20, 288, 57272, 210, 1'h1}};
   logic [7:0] rt [4][3] = '{'{IX_DELAY, 8'hFF, 8'h0F},
      '{8'h7D, 8'hFF, 8'h00}, '{IX_HSTART, 8'hA5, 8'hA5},
      '{IX_OVE, 8'h3C, 8'h3C}};
   logic [7:0] cfg [7][2] = '{'{IX_OVS, 8'h00}, '{IX_OVE, 8'hFF},
      '{IX_EVS, 8'hFF}, '{IX_EVE, 8'hFF}, '{IX_MSB, 8'h0E},
      '{IX_DELAY, 8'h00}, '{IX_CTRL, 8'h00}};

   logic        core_clk, reset, read, write, line_start, field_start;
   logic        odd_field, teletext_serial_in, bit_request_out;
   logic        waitrequest, insert_active, insert_bit;
   logic [9:0]  address;
   logic [31:0] writedata, readdata, rd;
   logic [3:0]  byteenable;
   int          err_total, comparisons, nreq, first, rise_at, dur, rises;
   int          req_base, ins_base;

   ttx_insert ttx_insert_i (.core_clk(core_clk), .reset(reset),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest),
      .line_start(line_start), .field_start(field_start),
      .odd_field(odd_field), .teletext_serial_in(teletext_serial_in),
      .bit_request_out(bit_request_out), .insert_active(insert_active),
      .insert_bit(insert_bit));
   ttx_source_model ttx_source_model_i (.core_clk(core_clk),
      .reset(reset), .bit_request_out(bit_request_out),
      .request_data_delay(4'h0), .teletext_serial_in(teletext_serial_in));

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("Checks %0d, errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // The master never assumes a latency; waitrequest low or the 50-cycle bound ends a wait.
   task automatic bus(bit we, logic [7:0] ix, logic [7:0] wd);
      int n;
      n = 0;
      @(posedge core_clk);
      address   <= {ix, 2'h0};
      writedata <= {24'h0, wd};
      read      <= !we;
      write     <= we;
      do begin
         @(posedge core_clk);
         n++;
      end while (waitrequest !== 1'h0 && n < 50);
      if (n >= 50) chk("bus_wait", 32'h0, 32'h1);
      rd = readdata;
      read  <= 1'h0;
      write <= 1'h0;
   endtask

   task automatic run_line(bit odd);
      bit pb;
      nreq = 0; first = -1; rise_at = -1; dur = 0; rises = 0; pb = 1'h0;
      @(posedge core_clk);
      line_start  <= 1'h1;
      field_start <= 1'h1;
      odd_field   <= odd;
      @(posedge core_clk);
      line_start  <= 1'h0;
      field_start <= 1'h0;
      for (int c = 0; c < 1279; c++) begin
         @(posedge core_clk);
         if (bit_request_out === 1'h1) begin
            if (first < 0) first = c;
            nreq++;
         end
         if (insert_active === 1'h1) begin
            if (rise_at < 0) rise_at = c;
            dur++;
            if (insert_bit === 1'h1 && !pb) rises++;
         end
         pb = (insert_active === 1'h1 && insert_bit === 1'h1);
      end
   endtask

   initial begin
      core_clk = 1'h0;
      forever #25 core_clk = ~core_clk;
   end

   initial begin
      repeat (30000) @(posedge core_clk);
      err_total++;
      print_verdict();
   end

   initial begin
      int exp;
      {reset, read, write, line_start, field_start, odd_field} = 6'h20;
      address = 10'h000; writedata = 32'h0; byteenable = 4'hF;
      err_total = 0; comparisons = 0;
      repeat (16) @(posedge core_clk);
      reset <= 1'h0;
      foreach (rt[i]) begin
         bus(1'h0, rt[i][0], 8'h00);
         chk("reg_reset", 32'h0, rd);
         bus(1'h1, rt[i][0], rt[i][1]);
         bus(1'h0, rt[i][0], 8'h00);
         chk("reg_value", {24'h0, rt[i][2]}, rd);
      end
      byteenable <= 4'h0;
      bus(1'h1, IX_HSTART, 8'h11);
      byteenable <= 4'hF;
      bus(1'h0, IX_HSTART, 8'h00);
      chk("lane_off", 32'hA5, rd);
      foreach (cfg[i]) bus(1'h1, cfg[i][0], cfg[i][1]);
      run_line(1'h1);
      chk("req_off", 32'h0, nreq);
      chk("act_off", 32'h0, dur);
      bus(1'h1, IX_CTRL, 8'h20);
      foreach (rows[i]) begin
         bus(1'h1, IX_MODE, rows[i].mode);
         bus(1'h1, IX_HSTART, rows[i].hs);
         run_line(1'h1);
         if (i == 0) begin
            req_base = first - rows[i].hs;
            ins_base = rise_at - rows[i].ins;
            chk("ins_near", 32'h1, ins_base inside {[-1:2]});
            bus(1'h0, IX_STATUS, 8'h00);
            chk("underrun_set", 32'h4, rd & 32'h4);
            bus(1'h1, IX_STATUS, 8'h04);
         end
         chk("req_ofs", req_base, first - rows[i].hs);
         chk("ins_ofs", ins_base, rise_at - rows[i].ins);
         exp = rows[i].bits * 200000 / rows[i].rate;
         chk("win_len", 32'h1,
             dur >= exp - 1 && dur <= exp + 2);
         if (rows[i].dat) begin
            chk("req_count", rows[i].bits, nreq);
            chk("ins_ones", rows[i].bits / 2, rises);
         end
      end
      bus(1'h0, IX_STATUS, 8'h00);
      chk("underrun_clr", 32'h0, rd & 32'h4);
      run_line(1'h0);
      chk("req_even", 32'h0, nreq);
      chk("act_even", 32'h0, dur);
      bus(1'h1, IX_HSTART, 8'h5A);
      reset <= 1'h1;
      repeat (2) @(posedge core_clk);
      chk("rst_wait", 32'h1, waitrequest);
      chk("rst_req", 32'h0, bit_request_out);
      chk("rst_ins", 32'h0, insert_active);
      chk("rst_bit", 32'h0, insert_bit);
      reset <= 1'h0;
      bus(1'h0, IX_HSTART, 8'h00);
      chk("rst_hstart", {24'h0, RST_HSTART}, rd);
      bus(1'h0, IX_CTRL, 8'h00);
      chk("rst_enable", 32'h0, rd);
      print_verdict();
   end
endmodule // test_teletext_insert_timing
